// [logic/mvp_pkg.sv]
// package with register map, field codes and defaults of the post-processing block
package mvp_pkg;
   localparam int DATA_W = 32;
   localparam int VAL_W = 16;
   localparam int CH_N = 4;
   localparam int PK_N = 8;
   localparam int ADDR_W = 12;
   // global registers
   localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_MASK_LO = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_MASK_HI = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
   // per channel: base + 0x10*ch, +0 config, +4 output value
   localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_CH_STRIDE = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_CH_CFG = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_CH_VAL = 12'h004;
   // sampling codes: 0..3 are 12.5/14.3/16.7/20 us, 4..9 = 25..1000 us, 10 auto
   localparam logic [3:0] SMP_20US = 4'h3;
   localparam logic [3:0] SMP_50US = 4'h5;
   localparam logic [3:0] SMP_AUTO = 4'hA;
   localparam logic [2:0] LIM_25US = 3'h0;
   localparam logic [2:0] LIM_500US = 3'h4;
   localparam logic [2:0] LIM_1000US = 3'h5;
   localparam logic [3:0] LIM_TO_SMP = 4'h4;
   typedef enum logic [1:0] {RNG_NEAR = 2'b00, RNG_MED = 2'b01, RNG_FAR = 2'b10} mvp_range_type;
   typedef enum logic [2:0] {
      HOLD_OFF = 3'b000, HOLD_NORMAL = 3'b001, HOLD_PEAK = 3'b010, HOLD_BOTTOM = 3'b011,
      HOLD_SAMPLE = 3'b100, HOLD_APEAK = 3'b101, HOLD_ABOTTOM = 3'b110
   } mvp_hold_type;
   localparam logic [1:0] MED_OFF = 2'h0;
   localparam logic [1:0] MED_15 = 2'h2;
   localparam logic [1:0] MED_31 = 2'h3;
   localparam logic [4:0] AVG_256 = 5'h08;
   localparam logic [4:0] AVG_MAX = 5'h10;
   // channel config fields
   localparam int F_AVG = 0;
   localparam int F_MED = 5;
   localparam int F_HOLD = 7;
   localparam int F_DIR = 10;
   localparam int F_THK = 11;
   localparam int F_PKA = 12;
   localparam int F_PKB = 15;
   localparam int F_PER = 18;
   localparam int PER_W = 14;
   localparam logic [31:0] CH_CFG_RESET = 32'h01000068;
   // sample register fields
   localparam int F_SMP = 0;
   localparam int F_LO = 4;
   localparam int F_HI = 7;
   localparam int F_RNG = 10;
   localparam int F_NUM = 12;
   localparam logic [31:0] SAMPLE_RESET = 32'h00000605;
endpackage

// [logic/mvp_postprocess.sv]
// per-channel peak selection, median, average and hold stages with an APB register file
// Notes on behaviour
// (R1) sampling at or below 20 us uses a reduced span: near, medium or far
// (R2) medium sub-range is the initial reduced-span selection
// (R3) auto sampling stays between a lower and an upper limit from six values
// (R4) auto limits default to 25 us lower and 500 us upper
// (R5) direction sign: positive rises with distance, negative falls
// (R6) up to eight reflection peaks are found and indexed one to eight
// (R7) indices start at the sensor side, ascending for near, descending for far
// (R8) numbering direction defaults to near
// (R9) masked distance areas never yield measurement peaks
// (R10) moving mean over power-of-two depth 1 to 65536, default 256
// (R11) average depth one passes values unchanged
// (R12) median of sliding window off, 7, 15 or 31, default 31
// (R13) hold off outputs filtered value and ignores hold input
// (R14) normal hold freezes output while hold reset input is active
// (R15) peak hold outputs maximum over each holding period
// (R16) bottom hold outputs minimum over each holding period
// (R17) sample hold captures value at each rising edge of hold input
// (R18) auto peak tracks maximum once hold reset is detected
// (R19) auto bottom tracks minimum once hold reset is detected
// (R20) controller should pulse hold reset before trusting auto peak or bottom
// (R21) distance uses one selected peak, peak one by default
// (R22) thickness: no value if a peak is absent, zero if same peak twice
// (R23) four channels with own config; order median, average, hold
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
module mvp_postprocess #(
   parameter int MED_MAX = 31,
   parameter int AVG_LOG_MAX = 16
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [mvp_pkg::ADDR_W-1:0] PADDR,
   input wire logic [mvp_pkg::DATA_W-1:0] PWDATA,
   output logic [mvp_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PEAK_VALID,
   input wire logic [mvp_pkg::PK_N*mvp_pkg::VAL_W-1:0] PEAK_POS,
   input wire logic [mvp_pkg::PK_N-1:0] PEAK_FOUND,
   input wire logic [mvp_pkg::CH_N-1:0] HOLD_IN,
   input wire logic [3:0] AUTO_SMP,
   output logic [3:0] SAMPLE_SEL,
   output logic [1:0] RANGE_SEL,
   output logic REDUCED_SPAN,
   output logic [mvp_pkg::CH_N-1:0] OUT_VALID,
   output logic [mvp_pkg::CH_N*mvp_pkg::VAL_W-1:0] OUT_VALUE
);
   import mvp_pkg::*;
   localparam int MW = $clog2(MED_MAX + 1);

   logic [31:0] sample_reg;
   logic [31:0] mask_lo, mask_hi;
   logic [31:0] ch_cfg [CH_N];
   logic wr, rd_ok;
   logic [ADDR_W-1:0] ch_off;
   logic [1:0] ch_idx;
   logic in_ch;

   assign wr = PSEL && PENABLE && PWRITE;
   assign PREADY = 1'b1;
   assign ch_off = PADDR - ADDR_CH_BASE;
   assign ch_idx = ch_off[5:4];
   assign in_ch = (PADDR >= ADDR_CH_BASE) && (ch_off < ADDR_CH_STRIDE * 12'h004)
      && (ch_off[3:0] == ADDR_CH_CFG[3:0] || ch_off[3:0] == ADDR_CH_VAL[3:0]);
   assign rd_ok = in_ch || PADDR == ADDR_SAMPLE || PADDR == ADDR_MASK_LO
      || PADDR == ADDR_MASK_HI || PADDR == ADDR_STATUS;
   assign PSLVERR = PSEL && PENABLE && !rd_ok;

   // register writes; defaults medium range, 50 us, limits 25/500 us
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sample_reg <= SAMPLE_RESET; // [R2] [R4]
         mask_lo <= 32'h00000000;
         mask_hi <= 32'h00000000;
         for (int i = 0; i < CH_N; i++) begin
            ch_cfg[i] <= CH_CFG_RESET; // [R8] [R10] [R12] [R21]
         end
      end else if (wr) begin
         if (PADDR == ADDR_SAMPLE) begin
            sample_reg <= PWDATA & 32'h00000FFF;
         end
         if (PADDR == ADDR_MASK_LO) begin
            mask_lo <= PWDATA;
         end
         if (PADDR == ADDR_MASK_HI) begin
            mask_hi <= PWDATA;
         end
         if (in_ch && ch_off[3:0] == ADDR_CH_CFG[3:0]) begin
            ch_cfg[ch_idx] <= PWDATA; // [R23]
         end
      end
   end

   // sampling selection with auto limits clamp
   logic [3:0] smp_code, lo_code, hi_code, auto_c;
   assign smp_code = sample_reg[F_SMP+:4];
   assign lo_code = {1'b0, sample_reg[F_LO+:3]} + LIM_TO_SMP;
   assign hi_code = {1'b0, sample_reg[F_HI+:3]} + LIM_TO_SMP;
   always_comb begin
      auto_c = AUTO_SMP;
      if (auto_c < lo_code) begin
         auto_c = lo_code; // [R3]
      end else if (auto_c > hi_code) begin
         auto_c = hi_code; // [R3]
      end
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SAMPLE_SEL <= SMP_50US;
         REDUCED_SPAN <= 1'b0;
         RANGE_SEL <= RNG_MED;
      end else begin
         SAMPLE_SEL <= (smp_code == SMP_AUTO) ? auto_c : smp_code;
         REDUCED_SPAN <= smp_code <= SMP_20US; // [R1]
         RANGE_SEL <= sample_reg[F_RNG+:2];
      end
   end

   // peak numbering: keep unmasked peaks, index from sensor side
   logic [PK_N-1:0] live;
   logic [VAL_W-1:0] ordered [PK_N];
   logic [PK_N-1:0] ord_ok;
   logic [3:0] npk;
   always_comb begin
      for (int i = 0; i < PK_N; i++) begin
         live[i] = PEAK_FOUND[i] && !((PEAK_POS[i*VAL_W+:VAL_W] >= mask_lo[15:0]
            && PEAK_POS[i*VAL_W+:VAL_W] <= mask_lo[31:16])
            || (PEAK_POS[i*VAL_W+:VAL_W] >= mask_hi[15:0]
            && PEAK_POS[i*VAL_W+:VAL_W] <= mask_hi[31:16])); // [R9]
      end
   end
   // peaks arrive ordered from the sensor side; masked ones are squeezed out
   always_comb begin
      logic [3:0] k;
      k = 4'h0;
      for (int i = 0; i < PK_N; i++) begin
         ordered[i] = '0;
         ord_ok[i] = 1'b0;
      end
      for (int i = 0; i < PK_N; i++) begin
         if (live[i]) begin
            ordered[k[2:0]] = PEAK_POS[i*VAL_W+:VAL_W]; // [R6]
            ord_ok[k[2:0]] = 1'b1;
            k = k + 4'h1;
         end
      end
      npk = k;
   end

   genvar c;
   generate
      for (c = 0; c < CH_N; c++) begin : g_ch
         logic [31:0] cfg;
         logic [2:0] pa, pb, ia, ib;
         logic ok, pvalid;
         logic [VAL_W-1:0] raw, vsel;
         assign cfg = ch_cfg[c];
         assign pa = cfg[F_PKA+:3];
         assign pb = cfg[F_PKB+:3];
         // far numbering counts down from the last found peak
         assign ia = cfg[F_DIR] ? 3'(npk - 4'h1 - {1'b0, pa}) : pa; // [R7]
         assign ib = cfg[F_DIR] ? 3'(npk - 4'h1 - {1'b0, pb}) : pb; // [R7]
         always_comb begin
            ok = 1'b0;
            raw = '0;
            if (!cfg[F_THK]) begin
               ok = {1'b0, pa} < npk; // [R21]
               raw = ordered[ia];
            end else begin
               ok = {1'b0, pa} < npk && {1'b0, pb} < npk; // [R22]
               if (pa == pb) begin
                  raw = '0; // [R22]
               end else if (ordered[ia] > ordered[ib]) begin
                  raw = ordered[ia] - ordered[ib];
               end else begin
                  raw = ordered[ib] - ordered[ia];
               end
            end
            vsel = (cfg[F_DIR+8] && !cfg[F_THK]) ? VAL_W'(~raw + 1'b1) : raw; // [R5]
         end
         assign pvalid = PEAK_VALID && ok && (ord_ok != '0);

         // median: window of last MED_MAX values, rank count selects the middle
         logic [VAL_W-1:0] win [MED_MAX];
         logic [MW-1:0] wlen;
         logic [VAL_W-1:0] med;
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               for (int i = 0; i < MED_MAX; i++) begin
                  win[i] <= '0;
               end
            end else if (pvalid) begin
               win[0] <= vsel;
               for (int i = 1; i < MED_MAX; i++) begin
                  win[i] <= win[i-1];
               end
            end
         end
         always_comb begin
            logic [MW-1:0] lt, eq;
            lt = '0;
            eq = '0;
            unique case (cfg[F_MED+:2])
               MED_OFF: wlen = MW'(1);
               2'h1: wlen = MW'(7);
               MED_15: wlen = MW'(15);
               MED_31: wlen = MW'(MED_MAX);
            endcase
            med = win[0];
            for (int j = 0; j < MED_MAX; j++) begin
               lt = '0;
               eq = '0;
               for (int i = 0; i < MED_MAX; i++) begin
                  if (i < wlen && win[i] < win[j]) lt = lt + 1'b1;
                  if (i < wlen && win[i] == win[j]) eq = eq + 1'b1;
               end
               if (j < wlen && lt <= (wlen >> 1) && (lt + eq) > (wlen >> 1)) begin
                  med = win[j]; // [R12]
               end
            end
         end
         logic med_v;
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) med_v <= 1'b0;
            else med_v <= pvalid;
         end

         // moving mean via running sum and a history ring
         logic [VAL_W-1:0] hist [1 << AVG_LOG_MAX];
         logic [AVG_LOG_MAX-1:0] wp;
         logic [VAL_W+AVG_LOG_MAX-1:0] sum;
         logic [AVG_LOG_MAX:0] fill, depth;
         logic [4:0] lg;
         logic [VAL_W-1:0] old, avg;
         logic avg_v;
         assign lg = (cfg[F_AVG+:5] > AVG_MAX) ? AVG_MAX : cfg[F_AVG+:5];
         assign depth = (AVG_LOG_MAX+1)'(1) << lg;
         assign old = hist[AVG_LOG_MAX'(wp - AVG_LOG_MAX'(depth))];
         always_ff @(posedge CLK) begin
            if (med_v) hist[wp] <= med;
         end
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               wp <= '0;
               sum <= '0;
               fill <= '0;
               avg <= '0;
               avg_v <= 1'b0;
            end else begin
               avg_v <= med_v;
               if (med_v) begin
                  wp <= wp + 1'b1;
                  if (fill < depth) begin
                     fill <= fill + 1'b1;
                     sum <= sum + med;
                  end else begin
                     sum <= sum + med - old; // [R10]
                  end
               end
               if (med_v && lg == 5'h00) begin
                  avg <= med; // [R11]
               end else if (med_v) begin
                  avg <= VAL_W'((sum + med - ((fill < depth) ? '0 : old)) >> lg); // [R10]
               end
            end
         end

         // hold stage
         mvp_hold_type hm;
         logic h1, h2, h3;
         logic [VAL_W-1:0] hout, ext, rep;
         logic [PER_W-1:0] pcnt;
         logic armed;
         assign hm = mvp_hold_type'(cfg[F_HOLD+:3]);
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               h1 <= 1'b0;
               h2 <= 1'b0;
               h3 <= 1'b0;
            end else begin
               h1 <= HOLD_IN[c];
               h2 <= h1;
               h3 <= h2;
            end
         end
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               hout <= '0;
               ext <= '0;
               rep <= '0;
               pcnt <= '0;
               armed <= 1'b0;
            end else begin
               unique case (hm)
                  HOLD_OFF: hout <= avg; // [R13]
                  HOLD_NORMAL: if (!h2) hout <= avg; // [R14]
                  HOLD_PEAK, HOLD_BOTTOM: begin
                     if (avg_v) begin
                        if (pcnt >= cfg[F_PER+:PER_W]) begin
                           rep <= ext;
                           ext <= avg;
                           pcnt <= PER_W'(1);
                        end else begin
                           pcnt <= pcnt + 1'b1;
                           if ((hm == HOLD_PEAK) ? avg > ext : avg < ext) begin
                              ext <= avg; // [R15] [R16]
                           end
                        end
                     end
                     hout <= rep;
                  end
                  HOLD_SAMPLE: if (h2 && !h3) hout <= avg; // [R17]
                  HOLD_APEAK, HOLD_ABOTTOM: begin
                     if (h2 && !h3) begin
                        armed <= 1'b1;
                        ext <= avg; // [R18] [R19]
                     end else if (armed && avg_v) begin
                        if ((hm == HOLD_APEAK) ? avg > ext : avg < ext) ext <= avg;
                     end
                     hout <= ext;
                  end
                  default: hout <= avg;
               endcase
            end
         end
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) OUT_VALID[c] <= 1'b0;
            else OUT_VALID[c] <= avg_v;
         end
         assign OUT_VALUE[c*VAL_W+:VAL_W] = hout;
      end
   endgenerate

   // read mux
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PRDATA <= '0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= '0;
         if (PADDR == ADDR_SAMPLE) PRDATA <= sample_reg;
         if (PADDR == ADDR_MASK_LO) PRDATA <= mask_lo;
         if (PADDR == ADDR_MASK_HI) PRDATA <= mask_hi;
         if (PADDR == ADDR_STATUS) PRDATA <= {20'h00000, npk, SAMPLE_SEL, REDUCED_SPAN,
            1'b0, RANGE_SEL};
         if (in_ch && ch_off[3:0] == ADDR_CH_CFG[3:0]) PRDATA <= ch_cfg[ch_idx];
         if (in_ch && ch_off[3:0] == ADDR_CH_VAL[3:0]) begin
            PRDATA <= {16'h0000, OUT_VALUE[ch_idx*VAL_W+:VAL_W]};
         end
      end
   end

   property p_reduced;
      @(posedge CLK) disable iff (!RESET_N) (smp_code <= SMP_20US) |=> REDUCED_SPAN;
   endproperty
   a_reduced: assert property (p_reduced) else $error("reduced span missing"); // [R1]
   property p_autolim;
      @(posedge CLK) disable iff (!RESET_N)
      (smp_code == SMP_AUTO) |=> (SAMPLE_SEL >= $past(lo_code) && SAMPLE_SEL <= $past(hi_code));
   endproperty
   a_autolim: assert property (p_autolim) else $error("auto sampling out of limits"); // [R3]
   property p_off;
      @(posedge CLK) disable iff (!RESET_N)
      (g_ch[0].hm == HOLD_OFF) |=> (OUT_VALUE[VAL_W-1:0] == $past(g_ch[0].avg));
   endproperty
   a_off: assert property (p_off) else $error("hold off not transparent"); // [R13]
   property p_normal;
      @(posedge CLK) disable iff (!RESET_N)
      (g_ch[0].hm == HOLD_NORMAL && g_ch[0].h2) ##1 (g_ch[0].hm == HOLD_NORMAL)
      |-> $stable(OUT_VALUE[VAL_W-1:0]);
   endproperty
   a_normal: assert property (p_normal) else $error("normal hold not frozen"); // [R14]
   property p_samp;
      @(posedge CLK) disable iff (!RESET_N)
      (g_ch[0].hm == HOLD_SAMPLE && g_ch[0].h2 && !g_ch[0].h3)
      |=> OUT_VALUE[VAL_W-1:0] == $past(g_ch[0].avg);
   endproperty
   a_samp: assert property (p_samp) else $error("sample hold missed edge"); // [R17]
   property p_pass;
      @(posedge CLK) disable iff (!RESET_N)
      (g_ch[0].med_v && g_ch[0].lg == 5'h00) |=> g_ch[0].avg == $past(g_ch[0].med);
   endproperty
   a_pass: assert property (p_pass) else $error("depth one not a pass"); // [R11]
   property p_lat;
      @(posedge CLK) disable iff (!RESET_N) g_ch[0].pvalid |-> ##3 OUT_VALID[0];
   endproperty
   a_lat: assert property (p_lat) else $error("output valid latency wrong"); // [R23]
   property p_thk0;
      @(posedge CLK) disable iff (!RESET_N)
      (ch_cfg[0][F_THK] && g_ch[0].pa == g_ch[0].pb) |-> g_ch[0].raw == '0;
   endproperty
   a_thk0: assert property (p_thk0) else $error("same peak thickness not zero"); // [R22]
   c_auto: cover property (@(posedge CLK) smp_code == SMP_AUTO);
   c_peak: cover property (@(posedge CLK) g_ch[0].hm == HOLD_PEAK && OUT_VALID[0]);
   c_apeak: cover property (@(posedge CLK) g_ch[1].armed);
endmodule

// [tb/mvp_sink.sv]
// downstream consumer model keeping the last value and a count per channel
`timescale 1ns/10ps
module mvp_sink (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [mvp_pkg::CH_N-1:0] OUT_VALID,
   input wire logic [mvp_pkg::CH_N*mvp_pkg::VAL_W-1:0] OUT_VALUE
);
   import mvp_pkg::*;
   logic [VAL_W-1:0] last [CH_N];
   int count [CH_N];
   // a value is taken only in the cycle its valid pulse stands
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < CH_N; i++) begin
            last[i] <= '0;
            count[i] <= 0;
         end
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            if (OUT_VALID[i] === 1'b1) begin
               last[i] <= OUT_VALUE[i*VAL_W +: VAL_W];
               count[i] <= count[i] + 1;
            end
         end
      end
   end
endmodule

// [tb/measured_value_postprocess_tb.sv]
// self-checking testbench of the measured value post-processing block
`timescale 1ns/10ps
module measured_value_postprocess_tb;
   import mvp_pkg::*;
   logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PEAK_VALID, REDUCED_SPAN, err;
   logic [ADDR_W-1:0] PADDR;
   logic [DATA_W-1:0] PWDATA, PRDATA, rdat;
   logic [PK_N*VAL_W-1:0] PEAK_POS;
   logic [PK_N-1:0] PEAK_FOUND;
   logic [CH_N-1:0] HOLD_IN, OUT_VALID;
   logic [3:0] AUTO_SMP, SAMPLE_SEL;
   logic [1:0] RANGE_SEL;
   logic [CH_N*VAL_W-1:0] OUT_VALUE;
   logic [VAL_W-1:0] v1;
   logic [VAL_W-1:0] pat [8] = '{16'h0A, 16'h46, 16'h1E, 16'h14, 16'h0A, 16'h46, 16'h1E, 16'h14};
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n0;

   mvp_postprocess i_mvp_postprocess (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .PEAK_VALID(PEAK_VALID), .PEAK_POS(PEAK_POS),
      .PEAK_FOUND(PEAK_FOUND), .HOLD_IN(HOLD_IN), .AUTO_SMP(AUTO_SMP),
      .SAMPLE_SEL(SAMPLE_SEL), .RANGE_SEL(RANGE_SEL), .REDUCED_SPAN(REDUCED_SPAN),
      .OUT_VALID(OUT_VALID), .OUT_VALUE(OUT_VALUE));
   mvp_sink i_mvp_sink (.CLK(CLK), .RESET_N(RESET_N), .OUT_VALID(OUT_VALID),
      .OUT_VALUE(OUT_VALUE));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   function automatic logic [DATA_W-1:0] lastw();
      return {16'h0, i_mvp_sink.last[0]};
   endfunction

   // setup then access, held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) begin
         @(posedge CLK);
      end
      rdat = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic smp(input logic [1:0] r, input logic [2:0] hi, lo, input logic [3:0] c);
      apb(1'b1, ADDR_SAMPLE, {20'h0, r, hi, lo, c});
      repeat (3) @(posedge CLK);
   endtask

   task automatic chcfg(input logic [PER_W-1:0] per, input logic [2:0] b, a,
      input logic thk, far, input logic [2:0] h, input logic [1:0] med, input logic [4:0] avg);
      apb(1'b1, ADDR_CH_BASE + ADDR_CH_CFG, {per, b, a, thk, far, h, med, avg});
   endtask

   // one profile pulse, then room for the three-cycle answer to reach the sink
   task automatic prof(input logic [VAL_W-1:0] p0, p1, p2, input logic [PK_N-1:0] f);
      PEAK_POS <= {{(5*VAL_W){1'b0}}, p2, p1, p0};
      PEAK_FOUND <= f;
      PEAK_VALID <= 1'b1;
      @(posedge CLK);
      PEAK_VALID <= 1'b0;
      repeat (5) @(posedge CLK);
   endtask

   task automatic feed(input logic [VAL_W-1:0] v, e);
      prof(v, 16'h0, 16'h0, 8'h01);
      check(lastw(), {16'h0, e});
   endtask

   task automatic hpulse();
      HOLD_IN <= 4'h1;
      repeat (4) @(posedge CLK);
      HOLD_IN <= 4'h0;
      repeat (4) @(posedge CLK);
   endtask

   task automatic t_reset();
      check({26'h0, REDUCED_SPAN, RANGE_SEL, SAMPLE_SEL[2:0]}, {26'h0, 1'b0, RNG_MED, 3'h5});
      apb(1'b0, ADDR_SAMPLE, 32'h0);
      check(rdat, {20'h0, RNG_MED, LIM_500US, LIM_25US, SMP_50US});
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rdat, {20'h0, 4'h0, SMP_50US, 1'b0, 1'b0, RNG_MED});
      apb(1'b0, ADDR_CH_BASE, 32'h0);
      check({14'h0, rdat[17:0]}, {14'h0, 6'h0, 2'b00, HOLD_OFF, MED_31, AVG_256});
      apb(1'b0, 12'hFF0, 32'h0);
      check({rdat[30:0], err}, 32'h1);
   endtask

   task automatic t_span();
      smp(RNG_MED, LIM_500US, LIM_25US, SMP_20US);
      check({29'h0, REDUCED_SPAN, RANGE_SEL}, {29'h0, 1'b1, RNG_MED});
      smp(RNG_NEAR, LIM_500US, LIM_25US, SMP_20US);
      check({29'h0, REDUCED_SPAN, RANGE_SEL}, {29'h0, 1'b1, RNG_NEAR});
      smp(RNG_FAR, LIM_500US, LIM_25US, SMP_20US);
      check({29'h0, REDUCED_SPAN, RANGE_SEL}, {29'h0, 1'b1, RNG_FAR});
      smp(RNG_FAR, LIM_500US, LIM_25US, 4'h4);
      check({31'h0, REDUCED_SPAN}, 32'h0);
   endtask

   task automatic t_auto();
      smp(RNG_MED, 3'h3, 3'h1, SMP_AUTO);
      AUTO_SMP <= 4'h9;
      repeat (3) @(posedge CLK);
      check({28'h0, SAMPLE_SEL}, 32'h7);
      AUTO_SMP <= 4'h4;
      repeat (3) @(posedge CLK);
      check({28'h0, SAMPLE_SEL}, 32'h5);
      AUTO_SMP <= 4'h6;
      repeat (3) @(posedge CLK);
      check({28'h0, SAMPLE_SEL}, 32'h6);
      smp(RNG_MED, LIM_500US, LIM_25US, SMP_50US);
   endtask

   task automatic t_pass();
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      n0 = i_mvp_sink.count[0];
      feed(16'h64, 16'h64);
      check(32'(i_mvp_sink.count[0] - n0), 32'h1);
      HOLD_IN <= 4'h1;
      feed(16'hC8, 16'hC8);
      HOLD_IN <= 4'h0;
      chcfg(14'h1, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      prof(16'h64, 16'h0, 16'h0, 8'h01);
      v1 = i_mvp_sink.last[0];
      prof(16'hC8, 16'h0, 16'h0, 8'h01);
      check({31'h0, i_mvp_sink.last[0] < v1}, 32'h1);
   endtask

   task automatic t_select();
      chcfg(14'h0, 3'h0, 3'h2, 1'b0, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h30);
      chcfg(14'h0, 3'h0, 3'h2, 1'b0, 1'b1, HOLD_OFF, MED_OFF, 5'h00);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h10);
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      apb(1'b1, ADDR_MASK_LO, 32'h00180008);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h20);
      apb(1'b1, ADDR_MASK_HI, 32'h00200020);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h30);
      apb(1'b1, ADDR_MASK_HI, 32'h00000001);
      apb(1'b1, ADDR_MASK_LO, 32'h00000001);
      chcfg(14'h0, 3'h2, 3'h0, 1'b1, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h20);
      n0 = i_mvp_sink.count[0];
      prof(16'h10, 16'h20, 16'h30, 8'h03);
      check(32'(i_mvp_sink.count[0] - n0), 32'h0);
      chcfg(14'h0, 3'h1, 3'h1, 1'b1, 1'b0, HOLD_OFF, MED_OFF, 5'h00);
      prof(16'h10, 16'h20, 16'h30, 8'h07);
      check(lastw(), 32'h0);
   endtask

   task automatic t_filter();
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_OFF, 2'h1, 5'h00);
      repeat (6) prof(16'h0A, 16'h0, 16'h0, 8'h01);
      feed(16'h3E8, 16'h0A);
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_OFF, MED_OFF, 5'h01);
      repeat (2) prof(16'h1E, 16'h0, 16'h0, 8'h01);
      feed(16'h0A, 16'h14);
   endtask

   task automatic t_hold();
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_NORMAL, MED_OFF, 5'h00);
      feed(16'h64, 16'h64);
      HOLD_IN <= 4'h1;
      repeat (4) @(posedge CLK);
      feed(16'hC8, 16'h64);
      HOLD_IN <= 4'h0;
      repeat (4) @(posedge CLK);
      feed(16'hC8, 16'hC8);
      chcfg(14'h0, 3'h0, 3'h0, 1'b0, 1'b0, HOLD_SAMPLE, MED_OFF, 5'h00);
      prof(16'h28, 16'h0, 16'h0, 8'h01);
      hpulse();
      feed(16'h5A, 16'h28);
      hpulse();
      feed(16'h11, 16'h5A);
      apb(1'b0, ADDR_CH_BASE + ADDR_CH_VAL, 32'h0);
      check(rdat, 32'h5A);
   endtask

   task automatic series(input logic [2:0] m, input logic [VAL_W-1:0] e);
      chcfg(14'h4, 3'h0, 3'h0, 1'b0, 1'b0, m, MED_OFF, 5'h00);
      hpulse();
      for (int i = 0; i < 8; i++) begin
         prof(pat[i], 16'h0, 16'h0, 8'h01);
      end
      check(lastw(), {16'h0, e});
   endtask

   initial begin
      {RESET_N, PSEL, PENABLE, PWRITE, PEAK_VALID, err} = '0;
      {PADDR, PWDATA, PEAK_POS, PEAK_FOUND, HOLD_IN} = '0;
      AUTO_SMP = 4'h5;
      repeat (3) @(posedge CLK);
      RESET_N <= 1'b1;
      @(posedge CLK);
      t_reset();
      t_span();
      t_auto();
      t_pass();
      t_select();
      t_filter();
      t_hold();
      series(HOLD_PEAK, 16'h46);
      series(HOLD_BOTTOM, 16'h0A);
      series(HOLD_APEAK, 16'h46);
      series(HOLD_ABOTTOM, 16'h0A);
      end_of_test();
   end
endmodule
